// [core/acs_pkg.sv]
package acs_pkg;
   // Conversion framing, counted in serial clock edges
   localparam int unsigned CONV_EDGES = 16;
   localparam int unsigned TRACK_CYCLES = 3;
   localparam logic [4:0] HOLD_FALL = 5'h04;
   localparam logic [4:0] LAST_FALL = 5'h10;
   localparam logic [3:0] CTRL_BITS = 4'h8;
   // Control byte layout
   localparam int unsigned CTRL_W = 8;
   localparam int unsigned ADDR_LSB = 3;
   localparam int unsigned ADDR_W = 3;
   // Result word: leading zeros then a straight binary result
   localparam int unsigned RESULT_W = 12;
   localparam int unsigned LEAD_ZEROS = 4;
   localparam int unsigned WORD_W = LEAD_ZEROS + RESULT_W;
   localparam int unsigned FIFO_DEPTH = 16;
   // Values after reset
   localparam logic [2:0] CHAN_RST = 3'h0;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // Gray coded along idle -> track -> convert -> auto power-down
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_TRACK = 2'b01,
      ACS_CONVERT = 2'b11,
      ACS_AUTO_PD = 2'b10
   } acs_state_e;
endpackage : acs_pkg

// [core/acs_sequencer.sv]
// What this block does
// - A frame opens on select falling, closes on select rising; convert only while low.
// - First three clock cycles of a conversion track the selected input.
// - Next thirteen cycles hold, convert and shift the result out MSB first.
// - Back to back: track after every sixteenth rise, hold at fourth fall.
// - Serial output driven while select low, released while select high.
// - Select high means power-down; select low is operational from first fall to sixteenth fall.
// - Clock gated while deselected; select falling with clock low is first fall.
// - Select falling with clock high waits for the next clock fall to track.
// - Serial input captured on the first eight rising edges of each conversion.
// - Select and clock falling together: next rising edge is the first capture.
// - Control byte bits 5..3 are the channel address; others have no effect.
// - Binary channel decode, 000 is channel one to 111 channel eight; default one.
// - No power-up delay and no dummy conversions; first result is full resolution.
// - The first conversion after power-up uses channel one.
// - Results are 12-bit straight binary codes.
// - Auto power-down from sixteenth fall until first fall of next conversion.
`timescale 1ns/1ps
`default_nettype none

module acs_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 16
) (
   input wire logic mclk, // System clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic in_valid, // Write request
   output logic in_ready, // Space available
   input wire logic [WIDTH-1:0] in_data, // Write data
   output logic out_valid, // Data available
   input wire logic out_ready, // Read acknowledge
   output logic [WIDTH-1:0] out_data // Head of queue
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic full;
      logic valid;
   } acs_fifo_s;

   acs_fifo_s fifo_r;
   acs_fifo_s fifo_nxt;
   logic push;
   logic pop;
   logic [AW:0] cnt_next;

   always_comb begin
      fifo_nxt = fifo_r;
      push = in_valid && !fifo_r.full;
      pop = out_ready && fifo_r.valid;
      cnt_next = fifo_r.cnt;
      if (clk_en) begin
         if (push) begin
            fifo_nxt.mem[fifo_r.wr] = in_data;
            fifo_nxt.wr = (fifo_r.wr == AW'(DEPTH - 1)) ? '0 : fifo_r.wr + 1'b1;
         end
         if (pop) begin
            fifo_nxt.rd = (fifo_r.rd == AW'(DEPTH - 1)) ? '0 : fifo_r.rd + 1'b1;
         end
         if (push && !pop) begin
            cnt_next = fifo_r.cnt + 1'b1;
         end else if (pop && !push) begin
            cnt_next = fifo_r.cnt - 1'b1;
         end
         fifo_nxt.cnt = cnt_next;
         fifo_nxt.full = (cnt_next == (AW+1)'(DEPTH));
         fifo_nxt.valid = (cnt_next != '0);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_r <= '0;
      end else begin
         fifo_r <= fifo_nxt;
      end
   end

   assign in_ready = !fifo_r.full;
   assign out_valid = fifo_r.valid;
   assign out_data = fifo_r.mem[fifo_r.rd];
endmodule : acs_fifo

module acs_sequencer
   import acs_pkg::*;
(
   input wire logic mclk, // System clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic clk_en, // Freezes all state while low
   input wire logic sclk, // Serial clock from the host
   input wire logic frame_select_n, // Frame select, active low
   input wire logic serial_in, // Control byte input
   output logic serial_out, // Result data output
   output logic serial_out_oe_n, // Output enable, low while driving
   output logic track, // Sampling node on the selected input
   output logic hold_strobe, // One-cycle pulse when the sample is held
   output logic [ADDR_W-1:0] chan_sel, // Channel of the running conversion
   output logic power_down, // Converter powered down
   output logic [CTRL_W-1:0] ctrl_byte, // Last complete control byte
   input wire logic result_valid, // Converted result offered
   output logic result_ready, // Result queue has room
   input wire logic [RESULT_W-1:0] result_data // Converted result
);
   typedef struct packed {
      acs_state_e st;
      logic [4:0] fall_cnt;
      logic [3:0] rise_cnt;
      logic [CTRL_W-1:0] ctrl_sh;
      logic [CTRL_W-1:0] ctrl;
      logic [ADDR_W-1:0] next_chan;
      logic [ADDR_W-1:0] chan;
      logic [WORD_W-1:0] out_sh;
      logic sclk_q;
      logic cs_q;
      logic sdo;
      logic oe_n;
      logic pd;
      logic trk;
      logic hold;
      logic rdy;
   } acs_seq_s;

   acs_seq_s seq_r;
   acs_seq_s seq_nxt;
   logic cs_low;
   logic int_fall;
   logic int_rise;
   logic start_conv;
   logic q_valid;
   logic q_ready;
   logic [RESULT_W-1:0] q_data;
   logic [WORD_W-1:0] word;
   logic [CTRL_W-1:0] byte_next;

   acs_fifo #(
      .WIDTH(RESULT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(result_valid),
      .in_ready(q_ready),
      .in_data(result_data),
      .out_valid(q_valid),
      .out_ready(start_conv),
      .out_data(q_data)
   );

   always_comb begin
      seq_nxt = seq_r;
      cs_low = !frame_select_n;
      // Internal clock fall: select falling with clock low, or clock falling in frame
      int_fall = cs_low && ((seq_r.cs_q && !sclk) || (!seq_r.cs_q && seq_r.sclk_q && !sclk));
      int_rise = cs_low && !seq_r.cs_q && !seq_r.sclk_q && sclk && (seq_r.st != ACS_IDLE);
      start_conv = clk_en && int_fall &&
         ((seq_r.st == ACS_IDLE) || (seq_r.st == ACS_AUTO_PD));
      // An empty queue shifts out zero; previous result goes out this conversion
      word = {{LEAD_ZEROS{1'b0}}, (q_valid ? q_data : {RESULT_W{1'b0}})};
      byte_next = {seq_r.ctrl_sh[CTRL_W-2:0], serial_in};
      if (clk_en) begin
         seq_nxt.sclk_q = sclk;
         seq_nxt.cs_q = !cs_low;
         seq_nxt.hold = 1'b0;
         seq_nxt.rdy = q_ready;
         if (!cs_low) begin
            seq_nxt.st = ACS_IDLE;
            seq_nxt.oe_n = 1'b1;
            seq_nxt.pd = 1'b1;
            seq_nxt.trk = 1'b0;
            seq_nxt.fall_cnt = '0;
            seq_nxt.rise_cnt = '0;
         end else begin
            seq_nxt.oe_n = 1'b0;
            if (int_fall) begin
               case (seq_r.st)
                  ACS_IDLE, ACS_AUTO_PD: begin
                     // No warm-up: every conversion is a real one
                     seq_nxt.st = ACS_TRACK;
                     seq_nxt.trk = 1'b1;
                     seq_nxt.pd = 1'b0;
                     seq_nxt.fall_cnt = 5'h01;
                     seq_nxt.rise_cnt = '0;
                     seq_nxt.chan = seq_r.next_chan;
                     seq_nxt.sdo = word[WORD_W-1];
                     seq_nxt.out_sh = {word[WORD_W-2:0], 1'b0};
                  end
                  default: begin
                     seq_nxt.fall_cnt = seq_r.fall_cnt + 5'h01;
                     seq_nxt.sdo = seq_r.out_sh[WORD_W-1];
                     seq_nxt.out_sh = {seq_r.out_sh[WORD_W-2:0], 1'b0};
                     if (seq_r.fall_cnt + 5'h01 == HOLD_FALL) begin
                        seq_nxt.st = ACS_CONVERT;
                        seq_nxt.trk = 1'b0;
                        seq_nxt.hold = 1'b1;
                     end else if (seq_r.fall_cnt + 5'h01 == LAST_FALL) begin
                        seq_nxt.st = ACS_AUTO_PD;
                        seq_nxt.pd = 1'b1;
                     end
                  end
               endcase
            end
            if (int_rise && (seq_r.rise_cnt < CTRL_BITS)) begin
               seq_nxt.rise_cnt = seq_r.rise_cnt + 4'h1;
               seq_nxt.ctrl_sh = byte_next;
               if (seq_r.rise_cnt == CTRL_BITS - 4'h1) begin
                  seq_nxt.ctrl = byte_next;
                  seq_nxt.next_chan = byte_next[ADDR_LSB+ADDR_W-1:ADDR_LSB];
               end
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         seq_r <= '0;
         seq_r.st <= ACS_IDLE;
         seq_r.chan <= CHAN_RST;
         seq_r.next_chan <= CHAN_RST;
         seq_r.ctrl <= CTRL_RST;
         seq_r.cs_q <= 1'b1;
         seq_r.oe_n <= 1'b1;
         seq_r.pd <= 1'b1;
      end else begin
         seq_r <= seq_nxt;
      end
   end

   assign serial_out = seq_r.sdo;
   assign serial_out_oe_n = seq_r.oe_n;
   assign track = seq_r.trk;
   assign hold_strobe = seq_r.hold;
   assign chan_sel = seq_r.chan;
   assign power_down = seq_r.pd;
   assign ctrl_byte = seq_r.ctrl;
   assign result_ready = seq_r.rdy;
endmodule : acs_sequencer

`default_nettype wire

// [verification/acs_host.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_host (
   input wire logic mclk, // Clock
   output logic sclk, // Serial clock
   output logic frame_select_n, // Select
   output logic serial_in, // Control bits
   input wire logic serial_out // Result bits
);
   initial begin
      sclk = 1'b0;
      frame_select_n = 1'b1;
      serial_in = 1'b0;
   end
   // One conversion: sixteen clock cycles, result taken at each rise
   task automatic conv(input logic [7:0] c, output logic [15:0] w);
      for (int i = 0; i < 16; i++) begin
         serial_in <= (i < 8) ? c[7-i] : ~serial_in;
         frame_select_n <= 1'b0;
         sclk <= 1'b0;
         repeat (4) @(posedge mclk);
         w[15-i] = serial_out;
         sclk <= 1'b1;
         repeat (4) @(posedge mclk);
      end
   endtask : conv
   task automatic stop();
      frame_select_n <= 1'b1;
      @(posedge mclk);
      sclk <= 1'b0;
      serial_in <= ~serial_in;
      repeat (4) @(posedge mclk);
   endtask : stop
endmodule : acs_host
`default_nettype wire

// [verification/acs_sequencer_props.sv]
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_props
   import acs_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic rst_n, // Reset
   input wire logic clk_en, // Run
   input wire logic sclk, // Serial clock
   input wire logic frame_select_n, // Select
   input wire logic serial_in, // Data in
   input wire logic serial_out, // Data out
   input wire logic serial_out_oe_n, // Out enable
   input wire logic track, // Track
   input wire logic hold_strobe, // Hold
   input wire logic [ADDR_W-1:0] chan_sel, // Channel
   input wire logic power_down, // Asleep
   input wire logic [CTRL_W-1:0] ctrl_byte, // Control
   input wire logic result_valid, // Offer
   input wire logic result_ready, // Room
   input wire logic [RESULT_W-1:0] result_data // Result
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_oe; clk_en |=> serial_out_oe_n == $past(frame_select_n); endproperty
   a_oe: assert property (p_oe) else $error("oe_n lag wrong");
   property p_desel; frame_select_n && clk_en |=> power_down && !track; endproperty
   a_desel: assert property (p_desel) else $error("active while deselected");
   property p_hold; $rose(hold_strobe) |-> $fell(track); endproperty
   a_hold: assert property (p_hold) else $error("hold without track end");
   property p_pulse; hold_strobe && clk_en |=> !hold_strobe && !track; endproperty
   a_pulse: assert property (p_pulse) else $error("hold pulse wrong");
   property p_dout;
      $changed(serial_out) && !$past(frame_select_n) && !$past(frame_select_n, 2)
         |-> $past(sclk, 2) && !$past(sclk);
   endproperty
   a_dout: assert property (p_dout) else $error("output moved off a fall");
   property p_chan; $changed(chan_sel) |-> $rose(track); endproperty
   a_chan: assert property (p_chan) else $error("channel moved mid conversion");
   property p_ctrl; $changed(ctrl_byte) |-> $past(sclk) && !$past(sclk, 2); endproperty
   a_ctrl: assert property (p_ctrl) else $error("control byte off a rise");
   property p_trk; track |-> !power_down && !serial_out_oe_n; endproperty
   a_trk: assert property (p_trk) else $error("tracking while asleep");
endmodule : acs_sequencer_props
bind acs_sequencer acs_sequencer_props u_props (.*);
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top import acs_pkg::*;;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic result_valid = 1'b0;
   logic [RESULT_W-1:0] result_data = 12'h000;
   logic sclk, frame_select_n, serial_in, serial_out, serial_out_oe_n, track;
   logic hold_strobe, power_down, result_ready;
   logic [ADDR_W-1:0] chan_sel;
   logic [CTRL_W-1:0] ctrl_byte;
   logic [15:0] w;
   int fails = 0;
   int n_compared = 0;
   initial begin
      forever #4 mclk = ~mclk;
   end
   acs_host host (
      .mclk(mclk),
      .sclk(sclk),
      .frame_select_n(frame_select_n),
      .serial_in(serial_in),
      .serial_out(serial_out)
   );
   acs_sequencer dut (
      .mclk(mclk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .sclk(sclk),
      .frame_select_n(frame_select_n),
      .serial_in(serial_in),
      .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n),
      .track(track),
      .hold_strobe(hold_strobe),
      .chan_sel(chan_sel),
      .power_down(power_down),
      .ctrl_byte(ctrl_byte),
      .result_valid(result_valid),
      .result_ready(result_ready),
      .result_data(result_data)
   );
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic complete_run();
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic push(input logic [RESULT_W-1:0] d);
      result_data <= d;
      result_valid <= 1'b1;
      @(posedge mclk);
      result_valid <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : push
   task automatic t_fill_drain();
      int k;
      logic [2:0] ch;
      logic [7:0] c;
      k = 0;
      ch = 3'h0;
      while (result_ready === 1'b1 && k < 20) begin
         push(12'h5A0 + 12'(k));
         k++;
      end
      check("depth", 16'(FIFO_DEPTH), 16'(k));
      for (int i = 0; i < 17; i++) begin
         c = {i[1:0], i[2:0], ~i[2:0]};
         host.conv(c, w);
         check("word", (i < 16) ? {4'h0, 12'h5A0 + 12'(i)} : 16'h0000, w);
         check("chan", 16'(ch), 16'(chan_sel));
         check("ctrl", 16'(c), 16'(ctrl_byte));
         ch = c[5:3];
      end
      host.stop();
      $display("fill_drain done");
   endtask : t_fill_drain
   task automatic t_sync_fall();
      push(12'h123);
      host.sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      host.conv(8'h28, w);
      check("sync word", 16'h0123, w);
      check("sync ctrl", 16'h0028, 16'(ctrl_byte));
      host.stop();
      $display("sync_fall done");
   endtask : t_sync_fall
   task automatic t_late_clock();
      int n_trk;
      int n_hold;
      int n_awake;
      n_trk = 0;
      n_hold = 0;
      n_awake = 0;
      push(12'hABC);
      host.sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      host.frame_select_n <= 1'b0;
      repeat (6) @(posedge mclk);
      check("early track", 16'h0000, 16'(track));
      check("oe driving", 16'h0000, 16'(serial_out_oe_n));
      // One conversion is 16 serial cycles of 8 mclk each in the host model
      fork
         host.conv(8'h00, w);
         begin
            repeat (128) begin
               @(posedge mclk);
               if (track === 1'b1) begin
                  n_trk++;
               end
               if (hold_strobe === 1'b1) begin
                  n_hold++;
               end
               if (power_down === 1'b0) begin
                  n_awake++;
               end
            end
         end
      join
      check("track cycles", 16'h0018, 16'(n_trk));
      check("hold pulses", 16'h0001, 16'(n_hold));
      check("awake cycles", 16'h0078, 16'(n_awake));
      check("late word", 16'h0ABC, w);
      check("late chan", 16'h0005, 16'(chan_sel));
      host.stop();
      check("oe released", 16'h0001, 16'(serial_out_oe_n));
      check("asleep", 16'h0001, 16'(power_down));
      $display("late_clock done");
   endtask : t_late_clock
   task automatic t_freeze();
      push(12'h03C5);
      clk_en <= 1'b0;
      host.frame_select_n <= 1'b0;
      // Offered while frozen: the queue must not take it
      push(12'h0777);
      check("frozen track", 16'h0000, 16'(track));
      check("frozen oe", 16'h0001, 16'(serial_out_oe_n));
      clk_en <= 1'b1;
      host.conv(8'h08, w);
      check("freeze word", 16'h03C5, w);
      check("freeze chan", 16'h0000, 16'(chan_sel));
      host.conv(8'h00, w);
      check("thaw word", 16'h0000, w);
      check("thaw chan", 16'h0001, 16'(chan_sel));
      host.stop();
      $display("freeze done");
   endtask : t_freeze
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      t_fill_drain();
      t_sync_fall();
      t_late_clock();
      t_freeze();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
